/* File: shared/flash_cmd_defs.svh */
/*
 * Offsets, bit positions, command codes and reset values of the flash
 * command and status block.
 * Assumes inclusion by bare name, from the design and bench files.
 */
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

`define FC_OFF_STATUS 8'h00
`define FC_OFF_CMD 8'h04
`define FC_OFF_DIV 8'h08
`define FC_OFF_PROT 8'h0C
`define FC_OFF_ARRW 8'h10
`define FC_OFF_SEC 8'h14

`define FC_BIT_CBEF 7
`define FC_BIT_CC 6
`define FC_BIT_PVIOL 5
`define FC_BIT_ACCERR 4
`define FC_BIT_BLANK 2

`define FC_CMD_BLANK 8'h05
`define FC_CMD_BYTE 8'h20
`define FC_CMD_BURST 8'h25
`define FC_CMD_PAGE 8'h40
`define FC_CMD_MASS 8'h41

`define FC_PAGE_BITS 9
`define FC_ADDR_W 16
`define FC_PROT_RESET 8'hFF
`define FC_SEC_RESET 2'h0
`define FC_SEC_OPEN 2'h2
`define FC_RESP_OKAY 2'h0
`define FC_RESP_SLVERR 2'h2

`endif

/* File: shared/flash_cmd_pkg.sv */
/*
 * Types of the flash command and status block.
 * Assumes nothing beyond the compile order.
 */
`default_nettype none

package flash_cmd_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} seq_t;
endpackage : flash_cmd_pkg

`default_nettype wire

/* File: core/flash_command_status_ctrl.sv */
/*
 * Flash command launch and status logic behind an AXI4-Lite slave.
 * Assumes the array answers each arr_go pulse with one arr_done pulse,
 * with arr_blank valid alongside it for a blank check.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`include "flash_cmd_defs.svh"
`default_nettype none

module flash_command_status_ctrl (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stop_req,
	input wire logic arr_done,
	input wire logic arr_blank,
	output logic arr_go,
	output logic [7:0] arr_op,
	output logic [`FC_ADDR_W-1:0] arr_addr,
	output logic [7:0] arr_data,
	output logic [1:0] security_state
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic cmd_legal(input logic [7:0] c);
		return c == `FC_CMD_BLANK || c == `FC_CMD_BYTE
			|| c == `FC_CMD_BURST || c == `FC_CMD_PAGE
			|| c == `FC_CMD_MASS;
	endfunction : cmd_legal

	// everything except blank check alters the array
	function automatic logic prog_erase(input logic [7:0] c);
		return c != `FC_CMD_BLANK;
	endfunction : prog_erase

	// locations above {select,0x1FF} are protected unless disabled
	function automatic logic prot_hit(input logic [7:0] c,
		input logic [`FC_ADDR_W-1:0] a, input logic [7:0] p);
		logic [`FC_ADDR_W-1:0] last_open;
		last_open = {p[7:1], {`FC_PAGE_BITS{1'b1}}};
		if (p[0] || !prog_erase(c))
			return 1'b0;
		return c == `FC_CMD_MASS || a > last_open;
	endfunction : prot_hit

	////////////////////////////////////////////////////////////////////////
	logic rst_meta_r, rst_n_r;

	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end

	////////////////////////////////////////////////////////////////////////
	// bus slave: one write and one read outstanding
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, rdata_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic wr_fire, wr_en, rd_hit, wr_hit;
	logic cbef_r, cc_r, pviol_r, acc_r, blank_r;
	logic [7:0] cmd_r, div_r, prot_r;
	logic [`FC_ADDR_W-1:0] arrw_addr_r;
	logic [7:0] arrw_data_r;
	logic [7:0] status_w;

	assign status_w = {cbef_r, cc_r, pviol_r, acc_r, 1'b0, blank_r, 2'b00};
	assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wr_hit = aw_addr_r <= `FC_OFF_SEC && aw_addr_r[1:0] == 2'b00;
	assign rd_hit = s_axi_araddr <= `FC_OFF_SEC
		&& s_axi_araddr[1:0] == 2'b00;
	// byte lane 0 carries every register's low byte
	assign wr_en = wr_fire && wr_hit && w_strb_r[0];

	always_comb
	begin
		aw_hold_nxt = aw_hold_r;
		aw_addr_nxt = aw_addr_r;
		w_hold_nxt = w_hold_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		rvalid_nxt = s_axi_rvalid;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (wr_fire)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = rd_hit ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
			unique case (s_axi_araddr)
				`FC_OFF_STATUS: rdata_nxt = {24'h000000, status_w};
				`FC_OFF_CMD: rdata_nxt = {24'h000000, cmd_r};
				`FC_OFF_DIV: rdata_nxt = {24'h000000, div_r};
				`FC_OFF_PROT: rdata_nxt = {24'h000000, prot_r};
				`FC_OFF_ARRW: rdata_nxt = {arrw_addr_r, 8'h00, arrw_data_r};
				`FC_OFF_SEC: rdata_nxt = {30'h0, security_state};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
		awready_nxt = !aw_hold_nxt && !bvalid_nxt;
		wready_nxt = !w_hold_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_n_r)
		if (!rst_n_r)
		begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_hold_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_hold_r <= w_hold_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
		end

	////////////////////////////////////////////////////////////////////////
	// command sequencer: one buffered command, plus one running only if both are bursts
	flash_cmd_pkg::seq_t seq_r, seq_nxt;
	logic cbef_nxt, cc_nxt, pviol_nxt, acc_nxt, blank_nxt;
	logic [7:0] cmd_nxt, div_nxt, prot_nxt;
	logic div_set_r, div_set_nxt, pend_r, pend_nxt, run_r, run_nxt;
	logic [7:0] pend_cmd_r, pend_cmd_nxt, pend_data_r, pend_data_nxt;
	logic [`FC_ADDR_W-1:0] pend_addr_r, pend_addr_nxt;
	logic [`FC_ADDR_W-1:0] arrw_addr_nxt;
	logic [7:0] arrw_data_nxt;
	logic go_nxt, handoff, launch, accept, seq_err, bad_code, no_div;
	logic queue_bad, protect;
	logic [7:0] op_nxt, data_nxt;
	logic [`FC_ADDR_W-1:0] addr_nxt;
	logic [1:0] sec_nxt;
	logic wr_st, wr_cmd, wr_arr;

	assign wr_st = wr_en && aw_addr_r == `FC_OFF_STATUS;
	assign wr_cmd = wr_en && aw_addr_r == `FC_OFF_CMD;
	assign wr_arr = wr_en && aw_addr_r == `FC_OFF_ARRW;
	// a 1 written while the buffer is full has nothing to launch
	assign launch = wr_st && w_data_r[`FC_BIT_CBEF] && cbef_r;
	assign seq_err = seq_r != flash_cmd_pkg::SEQ_CMD;
	assign bad_code = !cmd_legal(cmd_r);
	assign no_div = prog_erase(cmd_r) && !div_set_r;
	assign queue_bad = (run_r || pend_r) && !(cmd_r == `FC_CMD_BURST
		&& arr_op == `FC_CMD_BURST && !pend_r);
	assign protect = prot_hit(cmd_r, arrw_addr_r, prot_r);
	assign accept = launch && !seq_err && !bad_code && !no_div
		&& !queue_bad && !protect;
	assign handoff = pend_r && (!run_r || arr_done);

	always_comb
	begin
		seq_nxt = seq_r;
		cmd_nxt = cmd_r;
		div_nxt = div_r;
		div_set_nxt = div_set_r;
		prot_nxt = prot_r;
		arrw_addr_nxt = arrw_addr_r;
		arrw_data_nxt = arrw_data_r;
		cbef_nxt = cbef_r;
		pviol_nxt = pviol_r;
		acc_nxt = acc_r;
		blank_nxt = blank_r;
		pend_nxt = pend_r;
		pend_cmd_nxt = pend_cmd_r;
		pend_addr_nxt = pend_addr_r;
		pend_data_nxt = pend_data_r;
		run_nxt = run_r;
		go_nxt = 1'b0;
		op_nxt = arr_op;
		addr_nxt = arr_addr;
		data_nxt = arr_data;
		sec_nxt = security_state;
		// clears first so that a same-cycle set wins
		if (wr_st && w_data_r[`FC_BIT_PVIOL])
			pviol_nxt = 1'b0;
		if (wr_st && w_data_r[`FC_BIT_ACCERR])
			acc_nxt = 1'b0;
		if (wr_en && aw_addr_r == `FC_OFF_DIV)
		begin
			div_nxt = w_data_r[7:0];
			div_set_nxt = 1'b1;
		end
		if (wr_en && aw_addr_r == `FC_OFF_PROT)
			prot_nxt = w_data_r[7:0];
		if (wr_arr)
		begin
			arrw_addr_nxt = w_data_r[31:16];
			arrw_data_nxt = w_data_r[7:0];
			seq_nxt = flash_cmd_pkg::SEQ_DATA;
			if (seq_r != flash_cmd_pkg::SEQ_IDLE || !cbef_r)
			begin
				acc_nxt = 1'b1;
				seq_nxt = flash_cmd_pkg::SEQ_IDLE;
			end
		end
		if (wr_cmd)
		begin
			cmd_nxt = w_data_r[7:0];
			seq_nxt = flash_cmd_pkg::SEQ_CMD;
			if (seq_r != flash_cmd_pkg::SEQ_DATA)
			begin
				acc_nxt = 1'b1;
				seq_nxt = flash_cmd_pkg::SEQ_IDLE;
			end
		end
		if (launch)
		begin
			seq_nxt = flash_cmd_pkg::SEQ_IDLE;
			if (seq_err || bad_code || no_div || queue_bad)
				acc_nxt = 1'b1;
			else if (protect)
				pviol_nxt = 1'b1;
		end
		if (stop_req && (run_r || pend_r))
			acc_nxt = 1'b1;
		if (run_r && arr_done)
		begin
			run_nxt = 1'b0;
			if (arr_op == `FC_CMD_BLANK)
			begin
				blank_nxt = arr_blank;
				if (arr_blank)
					sec_nxt = `FC_SEC_OPEN;
			end
		end
		if (handoff)
		begin
			pend_nxt = 1'b0;
			cbef_nxt = 1'b1;
			run_nxt = 1'b1;
			go_nxt = 1'b1;
			op_nxt = pend_cmd_r;
			addr_nxt = pend_addr_r;
			data_nxt = pend_data_r;
		end
		// a full buffer ignores the 1, so a same-cycle handoff still frees it
		if (launch)
			cbef_nxt = 1'b0;
		if (accept)
		begin
			pend_nxt = 1'b1;
			pend_cmd_nxt = cmd_r;
			pend_addr_nxt = arrw_addr_r;
			pend_data_nxt = arrw_data_r;
			blank_nxt = 1'b0;
		end
		else if (launch)
			cbef_nxt = 1'b1; // rejected: command dropped, buffer free
		cc_nxt = cbef_nxt && !run_nxt && !pend_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_n_r)
		if (!rst_n_r)
		begin
			seq_r <= flash_cmd_pkg::SEQ_IDLE;
			cmd_r <= 8'h00;
			div_r <= 8'h00;
			div_set_r <= 1'b0;
			prot_r <= `FC_PROT_RESET;
			arrw_addr_r <= 16'h0000;
			arrw_data_r <= 8'h00;
			cbef_r <= 1'b1;
			cc_r <= 1'b1;
			pviol_r <= 1'b0;
			acc_r <= 1'b0;
			blank_r <= 1'b0;
			pend_r <= 1'b0;
			pend_cmd_r <= 8'h00;
			pend_addr_r <= 16'h0000;
			pend_data_r <= 8'h00;
			run_r <= 1'b0;
			arr_go <= 1'b0;
			arr_op <= 8'h00;
			arr_addr <= 16'h0000;
			arr_data <= 8'h00;
			security_state <= `FC_SEC_RESET;
		end
		else
		begin
			seq_r <= seq_nxt;
			cmd_r <= cmd_nxt;
			div_r <= div_nxt;
			div_set_r <= div_set_nxt;
			prot_r <= prot_nxt;
			arrw_addr_r <= arrw_addr_nxt;
			arrw_data_r <= arrw_data_nxt;
			cbef_r <= cbef_nxt;
			cc_r <= cc_nxt;
			pviol_r <= pviol_nxt;
			acc_r <= acc_nxt;
			blank_r <= blank_nxt;
			pend_r <= pend_nxt;
			pend_cmd_r <= pend_cmd_nxt;
			pend_addr_r <= pend_addr_nxt;
			pend_data_r <= pend_data_nxt;
			run_r <= run_nxt;
			arr_go <= go_nxt;
			arr_op <= op_nxt;
			arr_addr <= addr_nxt;
			arr_data <= data_nxt;
			security_state <= sec_nxt;
		end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_r);

	a_launch_holds_buffer: assert property (accept |=> !cbef_r && pend_r)
		else $error("buffer-empty still set after launch");
	a_handoff_frees: assert property (handoff |=> cbef_r && arr_go)
		else $error("handoff did not free buffer");
	a_queue_only_burst: assert property (accept && run_r
		|-> cmd_r == `FC_CMD_BURST && arr_op == `FC_CMD_BURST)
		else $error("non-burst command queued");
	a_complete_idle: assert property (cc_r
		|-> cbef_r && !run_r && !pend_r)
		else $error("complete set while busy");
	a_complete_drops: assert property (accept |=> !cc_r [*2])
		else $error("complete not cleared by launch");
	a_protect_drops: assert property (launch && !seq_err
		&& !bad_code && !no_div && !queue_bad && protect
		|=> pviol_r && !pend_r)
		else $error("protected command not dropped");
	a_divider_first: assert property (launch && no_div
		|=> acc_r && !pend_r)
		else $error("launch before divider not refused");
	a_illegal_code: assert property (launch && bad_code |=> acc_r)
		else $error("illegal code not flagged");
	a_stop_error: assert property (stop_req && run_r |=> acc_r)
		else $error("stop during command not flagged");
	a_error_sticky: assert property (acc_r && !(wr_st
		&& w_data_r[`FC_BIT_ACCERR]) |=> acc_r)
		else $error("access error lost without write of 1");
	a_blank_result: assert property (run_r && arr_done
		&& arr_op == `FC_CMD_BLANK |=> blank_r == $past(arr_blank))
		else $error("blank flag mismatch");
	a_unlock_state: assert property (run_r && arr_done && arr_blank
		&& arr_op == `FC_CMD_BLANK |=> security_state == `FC_SEC_OPEN)
		else $error("security not unlocked");

	c_burst_queue: cover property (accept && run_r);
	c_blank_pass: cover property (run_r && arr_done && arr_blank
		&& arr_op == `FC_CMD_BLANK);
	c_protect_hit: cover property (launch && protect);

endmodule : flash_command_status_ctrl

`default_nettype wire

/* File: tb/flash_array_model.sv */
/*
 * Behavioural model of the flash array behind the command block.
 * Assumes one arr_go pulse per operation, answered by one arr_done pulse.
 */
`include "flash_cmd_defs.svh"
`default_nettype none

module flash_array_model #(
	parameter int LAT = 40
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic arr_go,
	input wire logic [7:0] arr_op,
	output logic arr_done,
	output logic arr_blank
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic [7:0] op_r;
	logic erased_r;

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			cnt <= 0;
			erased_r <= 1'b0;
			arr_done <= 1'b0;
			arr_blank <= 1'b0;
		end
		else
		begin
			arr_done <= !arr_go && cnt == 1;
			// result line means nothing outside done: keep it moving
			arr_blank <= (!arr_go && cnt == 1) ? erased_r : ~arr_blank;
			if (arr_go)
			begin
				cnt <= LAT;
				op_r <= arr_op;
			end
			else if (cnt == 1)
			begin
				cnt <= 0;
				if (op_r == `FC_CMD_MASS)
					erased_r <= 1'b1;
				else if (op_r != `FC_CMD_BLANK)
					erased_r <= 1'b0;
			end
			else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule : flash_array_model

`default_nettype wire

/* File: tb/flash_command_status_ctrl_bench.sv */
/*
 * Self-checking bench of the flash command and status block.
 * Assumes the array model of flash_array_model and the register map.
 */
`include "flash_cmd_defs.svh"
`default_nettype none

module flash_command_status_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic stop_req = 1'b0;
	logic arr_done;
	logic arr_blank;
	logic arr_go;
	logic [7:0] arr_op;
	logic [15:0] arr_addr;
	logic [7:0] arr_data;
	logic [1:0] security_state;
	logic [7:0] go_op;
	logic [23:0] go_ad;
	logic [1:0] wr_resp;
	logic [1:0] rd_resp;
	logic [31:0] d;
	int n_go = 0;
	int n0;
	int cycles = 0;
	int miscompares = 0;
	int n_compared = 0;
	logic [7:0] codes [6] = '{8'h41, 8'h05, 8'h20, 8'h25, 8'h40, 8'h05};
	logic [31:0] exp_st [6] = '{32'hC0, 32'hC4, 32'hC0, 32'hC0, 32'hC0,
		32'hC0};

	flash_command_status_ctrl i_flash_command_status_ctrl (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .stop_req(stop_req),
		.arr_done(arr_done), .arr_blank(arr_blank), .arr_go(arr_go),
		.arr_op(arr_op), .arr_addr(arr_addr), .arr_data(arr_data),
		.security_state(security_state));

	flash_array_model #(.LAT(40)) i_flash_array_model (
		.sys_clk(sys_clk), .reset_n(reset_n), .arr_go(arr_go),
		.arr_op(arr_op), .arr_done(arr_done), .arr_blank(arr_blank));

	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		if (arr_go === 1'b1)
		begin
			n_go++;
			go_op = arr_op;
			go_ad = {arr_addr, arr_data};
		end
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// each task starts one edge on, so no strobe is driven twice at once
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		wr_resp = s_axi_bresp;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk(d, exp);
	endtask : rd_chk

	task automatic launch(input logic [15:0] a, input logic [7:0] v,
		input logic [7:0] c);
		axi_wr(`FC_OFF_ARRW, {a, 8'h00, v});
		axi_wr(`FC_OFF_CMD, {24'h0, c});
		axi_wr(`FC_OFF_STATUS, 32'h80);
	endtask : launch

	task automatic wait_idle();
		do
			axi_rd(`FC_OFF_STATUS);
		while (d[6] !== 1'b1);
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		while (s_axi_awready !== 1'b1)
			@(posedge sys_clk);
		rd_chk(`FC_OFF_STATUS, 32'hC0);
		rd_chk(`FC_OFF_SEC, 32'h0);
		launch(16'h0010, 8'h5A, `FC_CMD_BYTE);
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		axi_wr(`FC_OFF_STATUS, 32'h00);
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		axi_wr(`FC_OFF_STATUS, 32'h10);
		rd_chk(`FC_OFF_STATUS, 32'hC0);
		axi_wr(`FC_OFF_DIV, 32'h13);
		launch(16'h0010, 8'h5A, 8'h33);
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		axi_wr(`FC_OFF_STATUS, 32'h10);
		axi_wr(`FC_OFF_CMD, 32'h20);
		axi_wr(`FC_OFF_STATUS, 32'h80);
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		chk(n_go, 0);
		axi_wr(`FC_OFF_STATUS, 32'h10);
		foreach (codes[i])
		begin
			launch(16'h0200, 8'hA5, codes[i]);
			if (codes[i] == `FC_CMD_BYTE)
				rd_chk(`FC_OFF_STATUS, 32'h80);
			wait_idle();
			chk({24'h0, go_op}, {24'h0, codes[i]});
			rd_chk(`FC_OFF_STATUS, exp_st[i]);
			if (codes[i] == `FC_CMD_BYTE)
				chk({8'h0, go_ad}, 32'h0200A5);
		end
		rd_chk(`FC_OFF_SEC, 32'h2);
		n0 = n_go;
		launch(16'h0300, 8'h11, `FC_CMD_BURST);
		launch(16'h0301, 8'h22, `FC_CMD_BURST);
		rd_chk(`FC_OFF_STATUS, 32'h00);
		wait_idle();
		chk(n_go - n0, 2);
		chk({8'h0, go_ad}, 32'h030122);
		launch(16'h0302, 8'h33, `FC_CMD_BURST);
		launch(16'h0200, 8'h00, `FC_CMD_PAGE);
		rd_chk(`FC_OFF_STATUS, 32'h90);
		wait_idle();
		axi_wr(`FC_OFF_STATUS, 32'h10);
		axi_wr(`FC_OFF_STATUS, 32'h04);
		rd_chk(`FC_OFF_STATUS, 32'hC0);
		axi_wr(`FC_OFF_PROT, 32'h02);
		n0 = n_go;
		launch(16'h8000, 8'h01, `FC_CMD_BYTE);
		rd_chk(`FC_OFF_STATUS, 32'hE0);
		chk(n_go - n0, 0);
		axi_wr(`FC_OFF_STATUS, 32'h20);
		rd_chk(`FC_OFF_STATUS, 32'hC0);
		axi_wr(`FC_OFF_PROT, 32'hFF);
		launch(16'h0200, 8'h01, `FC_CMD_BYTE);
		stop_req <= 1'b1;
		@(posedge sys_clk);
		stop_req <= 1'b0;
		wait_idle();
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		chk({30'h0, security_state}, 32'h2);
		reset_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		while (s_axi_awready !== 1'b1)
			@(posedge sys_clk);
		rd_chk(`FC_OFF_STATUS, 32'hC0);
		chk({30'h0, security_state}, 32'h0);
		launch(16'h0010, 8'h5A, `FC_CMD_BYTE);
		rd_chk(`FC_OFF_STATUS, 32'hD0);
		axi_wr(8'h40, 32'h1);
		chk({30'h0, wr_resp}, {30'h0, `FC_RESP_SLVERR});
		rd_chk(8'h40, 32'h0);
		chk({30'h0, rd_resp}, {30'h0, `FC_RESP_SLVERR});
		summarize();
	end
endmodule : flash_command_status_ctrl_bench

`default_nettype wire
